/* File: verilog/ccl_pkg.sv */
// Constants, field layout and types of the convolver mode/config loader.
// Assumes one 100 MHz clock that also serves as the pixel clock.
package ccl_pkg;
   localparam logic [6:0] REG_A_ADDR = 7'h00;
   localparam logic [6:0] REG_B_ADDR = 7'h01;
   localparam logic [6:0] REG_C_ADDR = 7'h02;
   localparam logic [6:0] REG_D_ADDR = 7'h03;
   localparam logic [7:0] REG_A_RST = 8'h00;
   localparam logic [7:0] REG_B_RST = 8'h01;
   localparam logic [7:0] REG_C_RST = 8'h00;
   localparam logic [7:0] REG_D_RST = 8'h00;
   localparam int A_EXTRA_LSB = 0;
   localparam int A_CFG_LSB = 4;
   localparam int A_NOMUX_BIT = 7;
   localparam int B_SRC_BIT = 0;
   localparam int B_LSM_LSB = 1;
   localparam int B_PIPE4_BIT = 3;
   localparam int B_NOADD_BIT = 4;
   localparam int B_BYP_BIT = 7;
   localparam int C_AUTO_BIT = 0;
   localparam int C_DLY_LSB = 1;
   localparam int C_FLD_LSB = 4;
   localparam int C_GAIN_LSB = 6;
   localparam int D_XDLY_BIT = 0;
   localparam int D_X256_BIT = 1;
   localparam int D_LSD_LSB = 2;
   localparam int D_SGN_BIT = 4;
   localparam int D_DLY_LSB = 5;
   localparam int CLK_PERIOD_NS = 10;
   localparam int EPROM_ACC_NS = 150;
   localparam int ACC_CYC = (EPROM_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_BASE_CLK = 29;
   localparam int SYNC_STEP_CLK = 8;
   localparam int SYNC_MAX_CLK = 92;
   localparam logic [6:0] CTRL_LAST = 7'h08;
   localparam logic [6:0] COEF_FIRST = 7'h40;
   localparam logic [6:0] PAGE_LAST = 7'h7f;
   localparam int WORD_W = 15;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [2:0] {
      CFG_8B_8X8 = 3'b000,
      CFG_16B_8X4 = 3'b001,
      CFG_16B_4X4 = 3'b010,
      CFG_8B_8X4 = 3'b011,
      CFG_8B_4X4 = 3'b101
   } ccl_cfg_e;

   typedef enum logic [2:0] {
      LD_IDLE = 3'b000,
      LD_ADDR = 3'b001,
      LD_STRB = 3'b010,
      LD_PUSH = 3'b011,
      LD_DRAIN = 3'b100
   } ccl_state_e;
endpackage : ccl_pkg

/* File: verilog/ccl_wr_if.sv */
// Carrier for register write words (address and data) between modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface ccl_wr_if #(parameter int W = 15);
   logic valid;
   logic ready;
   logic [W-1:0] word;
   modport src (output valid, output word, input ready);
   modport snk (input valid, input word, output ready);
endinterface : ccl_wr_if

/* File: verilog/ccl_fifo.sv */
// Word FIFO with a registered read stage, valid/ready on both sides.
// Assumes a synchronised active-low reset and a common clock enable.
`timescale 1ns/1ns
module ccl_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clkEn,
   ccl_wr_if.snk inPort,
   ccl_wr_if.src outPort
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic outValid_reg;
   logic [WIDTH-1:0] outWord_reg;
   logic push;
   logic pop;

   assign inPort.ready = (count_reg != (AW+1)'(DEPTH));
   assign push = inPort.valid && inPort.ready;
   // Refill output stage when empty or being taken
   assign pop = (count_reg != '0) && (!outValid_reg || outPort.ready);
   assign outPort.valid = outValid_reg;
   assign outPort.word = outWord_reg;

   always_ff @(posedge mclk)
   begin
      if (clkEn && push)
      begin
         mem[wrPtr_reg] <= inPort.word;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end
      else if (clkEn)
      begin
         if (push)
         begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop)
         begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         outValid_reg <= 1'b0;
         outWord_reg <= '0;
      end
      else if (clkEn)
      begin
         if (pop)
         begin
            outValid_reg <= 1'b1;
            outWord_reg <= mem[rdPtr_reg];
         end
         else if (outPort.ready)
         begin
            outValid_reg <= 1'b0;
         end
      end
   end
endmodule : ccl_fifo

/* File: verilog/ccl_loader.sv */
// Mode register file, loader-mode sequencer and delayed sync output.
// Assumes pins are synchronous to mclk; mclk doubles as pixel clock.
`timescale 1ns/1ns
module ccl_loader (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic leadStrapN,
   input wire logic soloStrapN,
   input wire logic loaderSelectStrap,
   input wire logic chipEnableN,
   input wire logic [7:0] expansionLowerBus,
   input wire logic [6:0] expansionUpperBusIn,
   output logic [6:0] expansionUpperBusOut,
   output logic expansionUpperBusOeN,
   input wire logic hostDataStrobeIn,
   output logic hostDataStrobeOut,
   output logic hostDataStrobeOeN,
   input wire logic loadActiveNIn,
   output logic loadActiveNOut,
   output logic loadActiveNOeN,
   output logic [3:0] pageAddress,
   input wire logic chainStrobeInN,
   output logic chainStrobeOutN,
   input wire logic lineSyncIn,
   output logic delayedSyncOut,
   input wire logic skipFirstDelayPin,
   output logic cfgWrValid,
   output logic [14:0] cfgWrWord,
   input wire logic cfgWrReady,
   output logic [2:0] configSelect,
   output logic outputMuxDisable,
   output logic secondGroupFromPort,
   output logic [1:0] lineStoreMode,
   output logic [4:0] inputDelay,
   output logic expAdderDisable,
   output logic bypassFirstDelay,
   output logic autoFieldSelect,
   output logic [1:0] fieldSelect,
   output logic [1:0] gainMode,
   output logic expInputDelayed,
   output logic sumTimes256,
   output logic signedPixels
);
   import ccl_pkg::*;

   logic [1:0] rstPipe_reg;
   logic rstSync;
   ccl_state_e st_reg;
   logic [6:0] eAddr_reg;
   logic [3:0] block_reg;
   logic [3:0] extra_reg;
   logic [4:0] timer_reg;
   logic [7:0] dataLatch_reg;
   logic startPending_reg;
   logic ceLast_reg;
   logic strobeLast_reg;
   logic [7:0] regA_reg;
   logic [7:0] regB_reg;
   logic [7:0] regC_reg;
   logic [7:0] regD_reg;
   logic [SYNC_MAX_CLK-2:0] syncPipe_reg;
   logic [6:0] syncTap;
   logic leadOrSolo;
   logic epromMode;
   logic chainDone;
   logic hostWrite;
   logic wrTake;
   logic [6:0] wrAddr;
   logic [7:0] wrData;
   logic eightBitMode;

   ccl_wr_if #(.W(WORD_W)) fillIf ();
   ccl_wr_if #(.W(WORD_W)) drainIf ();

   ////////////////////////////////////////////////////////////////////
   // Reset release

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstPipe_reg <= 2'h0;
      end
      else
      begin
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
      end
   end
   assign rstSync = rstPipe_reg[1];

   ////////////////////////////////////////////////////////////////////
   // Mode decode

   assign leadOrSolo = !leadStrapN || !soloStrapN;
   assign epromMode = leadOrSolo && !loaderSelectStrap;
   // strobe end: solo closes its own loop
   assign chainDone = !soloStrapN ? !chainStrobeOutN : !chainStrobeInN;
   // Host or downstream write: falling strobe while enabled and loading
   assign hostWrite = !epromMode && !loadActiveNIn && !chipEnableN
      && strobeLast_reg && !hostDataStrobeIn;

   ////////////////////////////////////////////////////////////////////
   // Loader sequencer

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         ceLast_reg <= 1'b1;
         strobeLast_reg <= 1'b1;
      end
      else if (clkEn)
      begin
         ceLast_reg <= chipEnableN;
         strobeLast_reg <= hostDataStrobeIn;
      end
   end

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         startPending_reg <= 1'b1;
      end
      else if (clkEn)
      begin
         // chip enable restarts load; a new request beats the clear
         if (leadOrSolo && ceLast_reg && !chipEnableN)
         begin
            startPending_reg <= 1'b1;
         end
         else if (st_reg == LD_IDLE && epromMode && startPending_reg)
         begin
            startPending_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         st_reg <= LD_IDLE;
         eAddr_reg <= 7'h00;
         block_reg <= 4'h0;
         extra_reg <= 4'h0;
         timer_reg <= 5'h00;
         dataLatch_reg <= 8'h00;
      end
      else if (clkEn)
      begin
         unique case (st_reg)
            LD_IDLE:
            begin
               if (epromMode && startPending_reg)
               begin
                  st_reg <= LD_ADDR;
                  eAddr_reg <= 7'h00;
                  block_reg <= 4'h0;
                  // Address pin lags the counter by one flop
                  timer_reg <= 5'(ACC_CYC + 1);
               end
            end
            LD_ADDR:
            begin
               // Wait out the memory access time
               if (timer_reg == 5'h01)
               begin
                  st_reg <= LD_STRB;
                  dataLatch_reg <= expansionLowerBus;
                  if (block_reg == 4'h0 && eAddr_reg == REG_A_ADDR)
                  begin
                     extra_reg <= expansionLowerBus[A_EXTRA_LSB +: 4];
                  end
               end
               else
               begin
                  timer_reg <= timer_reg - 5'h01;
               end
            end
            LD_STRB:
            begin
               if (chainDone)
               begin
                  st_reg <= LD_PUSH;
               end
            end
            LD_PUSH:
            begin
               if (fillIf.ready)
               begin
                  timer_reg <= 5'(ACC_CYC + 1);
                  st_reg <= LD_ADDR;
                  if (eAddr_reg == PAGE_LAST)
                  begin
                     eAddr_reg <= 7'h00;
                     if (!soloStrapN || block_reg == extra_reg)
                     begin
                        st_reg <= LD_DRAIN;
                     end
                     else
                     begin
                        block_reg <= block_reg + 4'h1;
                     end
                  end
                  else if (eAddr_reg == CTRL_LAST)
                  begin
                     eAddr_reg <= COEF_FIRST;
                  end
                  else
                  begin
                     eAddr_reg <= eAddr_reg + 7'h01;
                  end
               end
            end
            LD_DRAIN:
            begin
               // Last word needs an edge to reach the output stage
               if (timer_reg != 5'h01)
               begin
                  timer_reg <= timer_reg - 5'h01;
               end
               else if (fillIf.ready && !drainIf.valid)
               begin
                  st_reg <= LD_IDLE;
               end
            end
            default:
            begin
               st_reg <= LD_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drivers

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         expansionUpperBusOut <= 7'h00;
         expansionUpperBusOeN <= 1'b1;
         hostDataStrobeOut <= 1'b1;
         hostDataStrobeOeN <= 1'b1;
         loadActiveNOut <= 1'b1;
         loadActiveNOeN <= 1'b1;
         pageAddress <= 4'h0;
         chainStrobeOutN <= 1'b1;
      end
      else if (clkEn)
      begin
         expansionUpperBusOut <= eAddr_reg;
         expansionUpperBusOeN <= !epromMode;
         hostDataStrobeOut <= !(st_reg == LD_ADDR && timer_reg == 5'h01)
            && !(st_reg == LD_STRB && !chainDone);
         hostDataStrobeOeN <= !epromMode;
         loadActiveNOut <= (st_reg == LD_IDLE && !(epromMode && startPending_reg))
            || (st_reg == LD_DRAIN && timer_reg == 5'h01 && fillIf.ready && !drainIf.valid);
         loadActiveNOeN <= !epromMode;
         pageAddress <= block_reg;
         chainStrobeOutN <= epromMode ? hostDataStrobeOut : hostDataStrobeIn;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write buffer

   assign fillIf.valid = (st_reg == LD_PUSH) || hostWrite;
   assign fillIf.word = epromMode ? {eAddr_reg, dataLatch_reg}
      : {expansionUpperBusIn, expansionLowerBus};
   assign drainIf.ready = cfgWrReady;
   assign cfgWrValid = drainIf.valid;
   assign cfgWrWord = drainIf.word;
   assign wrTake = drainIf.valid && cfgWrReady;
   assign wrAddr = drainIf.word[14:8];
   assign wrData = drainIf.word[7:0];

   // Host writes lost if full; host must pace by strobe width
   ccl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rstn(rstSync),
      .clkEn(clkEn),
      .inPort(fillIf),
      .outPort(drainIf)
   );

   ////////////////////////////////////////////////////////////////////
   // Mode registers

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         regA_reg <= REG_A_RST;
         regB_reg <= REG_B_RST;
         regC_reg <= REG_C_RST;
         regD_reg <= REG_D_RST;
      end
      else if (clkEn && wrTake)
      begin
         if (wrAddr == REG_A_ADDR)
         begin
            regA_reg <= wrData;
         end
         if (wrAddr == REG_B_ADDR)
         begin
            regB_reg <= wrData;
         end
         if (wrAddr == REG_C_ADDR)
         begin
            regC_reg <= wrData;
         end
         if (wrAddr == REG_D_ADDR)
         begin
            regD_reg <= wrData;
         end
      end
   end

   assign eightBitMode = (regA_reg[A_CFG_LSB +: 3] == CFG_8B_8X8)
      || (regA_reg[A_CFG_LSB +: 3] == CFG_8B_8X4)
      || (regA_reg[A_CFG_LSB +: 3] == CFG_8B_4X4);

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         configSelect <= 3'h0;
         outputMuxDisable <= 1'b0;
         secondGroupFromPort <= 1'b1;
         lineStoreMode <= 2'h0;
         inputDelay <= 5'h00;
         expAdderDisable <= 1'b0;
         bypassFirstDelay <= 1'b0;
         autoFieldSelect <= 1'b0;
         fieldSelect <= 2'h0;
         gainMode <= 2'h0;
         expInputDelayed <= 1'b0;
         sumTimes256 <= 1'b0;
         signedPixels <= 1'b0;
      end
      else if (clkEn)
      begin
         configSelect <= regA_reg[A_CFG_LSB +: 3];
         // mux off above 20MHz or with gain
         outputMuxDisable <= regA_reg[A_NOMUX_BIT] || (regC_reg[C_GAIN_LSB +: 2] != 2'h0);
         secondGroupFromPort <= regB_reg[B_SRC_BIT];
         lineStoreMode <= regB_reg[B_LSM_LSB +: 2];
         inputDelay <= {1'b0, regD_reg[D_LSD_LSB +: 2], 2'h0}
            + {2'h0, regB_reg[B_PIPE4_BIT], 2'h0};
         expAdderDisable <= regB_reg[B_NOADD_BIT] || leadOrSolo;
         bypassFirstDelay <= eightBitMode
            ? (regB_reg[B_BYP_BIT] && regA_reg[A_CFG_LSB +: 3] == CFG_8B_8X8)
            : skipFirstDelayPin;
         autoFieldSelect <= regC_reg[C_AUTO_BIT];
         fieldSelect <= regC_reg[C_FLD_LSB +: 2];
         gainMode <= regC_reg[C_GAIN_LSB +: 2];
         expInputDelayed <= regD_reg[D_XDLY_BIT];
         sumTimes256 <= regD_reg[D_X256_BIT];
         signedPixels <= regD_reg[D_SGN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Delayed sync

   // tap is total delay minus two flop stages
   assign syncTap = 7'(SYNC_BASE_CLK - 2) + {regC_reg[C_DLY_LSB +: 3], 3'h0}
      + {4'h0, regD_reg[D_DLY_LSB +: 3]};

   generate
      for (genvar i = 0; i < SYNC_MAX_CLK - 1; i++)
      begin : g_sync
         always_ff @(posedge mclk or negedge rstSync)
         begin
            if (!rstSync)
            begin
               syncPipe_reg[i] <= 1'b0;
            end
            else if (clkEn)
            begin
               syncPipe_reg[i] <= (i == 0) ? lineSyncIn : syncPipe_reg[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         delayedSyncOut <= 1'b0;
      end
      else if (clkEn)
      begin
         delayedSyncOut <= syncPipe_reg[syncTap];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks (clock enable assumed high)

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstSync);

   sequence s_strobeEnd;
      st_reg == LD_STRB && chainDone;
   endsequence
   sequence s_pageEnd;
      st_reg == LD_PUSH && fillIf.ready && eAddr_reg == PAGE_LAST;
   endsequence
   sequence s_minSync;
      $rose(lineSyncIn) && syncTap == 7'(SYNC_BASE_CLK - 2);
   endsequence

   property p_strobeEnd;
      clkEn throughout s_strobeEnd |=> hostDataStrobeOut && st_reg == LD_PUSH;
   endproperty
   a_strobeEnd: assert property (p_strobeEnd) else $error("strobe not ended");
   property p_addrHold;
      clkEn && st_reg == LD_STRB |-> hostDataStrobeOut == 1'b0
         && expansionUpperBusOut == eAddr_reg;
   endproperty
   a_addrHold: assert property (p_addrHold) else $error("address or strobe wrong");
   property p_loadLow;
      clkEn && st_reg != LD_IDLE && $past(st_reg) != LD_IDLE |-> !loadActiveNOut;
   endproperty
   a_loadLow: assert property (p_loadLow) else $error("load-active high mid load");
   property p_skip;
      clkEn && st_reg == LD_PUSH && fillIf.ready && eAddr_reg == CTRL_LAST
         |=> eAddr_reg == COEF_FIRST;
   endproperty
   a_skip: assert property (p_skip) else $error("unused locations not skipped");
   property p_blockStop;
      s_pageEnd and (clkEn && block_reg == extra_reg) |=> st_reg == LD_DRAIN;
   endproperty
   a_blockStop: assert property (p_blockStop) else $error("load did not stop");
   property p_adderOff;
      clkEn && leadOrSolo |=> expAdderDisable;
   endproperty
   a_adderOff: assert property (p_adderOff) else $error("adder not disabled");
   property p_muxOff;
      clkEn && regC_reg[C_GAIN_LSB +: 2] != 2'h0 |=> outputMuxDisable;
   endproperty
   a_muxOff: assert property (p_muxOff) else $error("mux not disabled");
   property p_syncMin;
      clkEn throughout s_minSync |-> ##29 delayedSyncOut;
   endproperty
   a_syncMin: assert property (p_syncMin) else $error("sync delay not 29");
   property p_start;
      clkEn && $rose(startPending_reg) && epromMode && st_reg == LD_IDLE
         |-> ##1 !loadActiveNOut;
   endproperty
   a_start: assert property (p_start) else $error("load did not start");
endmodule : ccl_loader

/* File: tb/ccl_eprom_model.sv */
// Paged EPROM model behind the loader's address and data pins.
// Assumes the solo or lead device drives the low address lines.
`timescale 1ns/1ns
module ccl_eprom_model (
   input wire logic mclk,
   input wire logic [6:0] addr,
   input wire logic addrOeN,
   input wire logic [3:0] page,
   output logic [7:0] data
);
   logic [7:0] lastData = 8'h00;
   always_ff @(posedge mclk)
   begin
      lastData <= data;
   end
   always_comb
   begin
      case (addr)
         7'h00: data = 8'h35;
         7'h01: data = 8'h1b;
         7'h02: data = 8'h5b;
         7'h03: data = 8'h76;
         default: data = {1'b0, addr} ^ {page, 4'h5};
      endcase
      // Undriven address: data must not look stable
      if (addrOeN)
      begin
         data = ~lastData;
      end
   end
endmodule : ccl_eprom_model

/* File: tb/tb_top.sv */
// Testbench: solo device loading from the EPROM model.
// Assumes chain pins looped back as on a solo board.
`timescale 1ns/1ns
module tb_top;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ceN = 1'b1;
   logic sync = 1'b0;
   logic rdy = 1'b0;
   logic [7:0] rom;
   logic [6:0] ad;
   logic [3:0] page;
   logic [14:0] word;
   logic [21:0] dec;
   logic adOeN, stOut, stOeN, ldOut, ldOeN, chOut, dSync, wv;
   logic [14:0] words[$];
   int n_mismatch = 0;
   int tests_run = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk)
      if (wv === 1'b1 && rdy) words.push_back(word);
   ccl_eprom_model i_ccl_eprom_model (.mclk(mclk), .addr(ad), .addrOeN(adOeN),
      .page(page), .data(rom));
   ccl_loader i_ccl_loader (.mclk(mclk), .rstn(rstn), .clkEn(1'b1), .leadStrapN(1'b1),
      .soloStrapN(1'b0), .loaderSelectStrap(1'b0), .chipEnableN(ceN),
      .expansionLowerBus(rom), .expansionUpperBusIn(ad), .expansionUpperBusOut(ad),
      .expansionUpperBusOeN(adOeN), .hostDataStrobeIn(stOut), .hostDataStrobeOut(stOut),
      .hostDataStrobeOeN(stOeN), .loadActiveNIn(ldOut), .loadActiveNOut(ldOut),
      .loadActiveNOeN(ldOeN), .pageAddress(page), .chainStrobeInN(chOut),
      .chainStrobeOutN(chOut), .lineSyncIn(sync), .delayedSyncOut(dSync),
      .skipFirstDelayPin(1'b0), .cfgWrValid(wv), .cfgWrWord(word), .cfgWrReady(rdy),
      .configSelect(dec[21:19]), .outputMuxDisable(dec[18]),
      .secondGroupFromPort(dec[17]), .lineStoreMode(dec[16:15]),
      .inputDelay(dec[14:10]), .expAdderDisable(dec[9]), .bypassFirstDelay(dec[8]),
      .autoFieldSelect(dec[7]), .fieldSelect(dec[6:5]), .gainMode(dec[4:3]),
      .expInputDelayed(dec[2]), .sumTimes256(dec[1]), .signedPixels(dec[0]));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] romv(input logic [6:0] a);
      logic [7:0] t[4];
      t = '{8'h35, 8'h1b, 8'h5b, 8'h76};
      romv = (a < 7'h04) ? t[a[1:0]] : ({1'b0, a} ^ 8'h05);
   endfunction : romv
   // Loader run with the write stream stalled long enough to fill the FIFO
   task automatic t_load;
      int i;
      int a;
      words.delete();
      rdy = 1'b0;
      repeat (20) @(negedge mclk);
      chk(ldOut, 1'b0);
      chk({stOeN, ldOeN, adOeN}, 3'h0);
      chk(page, 4'h0);
      repeat (800) @(negedge mclk);
      chk(ldOut, 1'b0);
      rdy = 1'b1;
      i = 0;
      while (ldOut !== 1'b1 && i < 4000)
      begin
         @(negedge mclk);
         i++;
      end
      chk(ldOut, 1'b1);
      chk(words.size(), 73);
      for (i = 0; i < 73; i++)
      begin
         a = (i < 9) ? i : i + 55;
         chk(words[i], {a[6:0], romv(a[6:0])});
      end
   endtask : t_load
   task automatic t_modes;
      chk(dec, 22'h1ea2ab);
   endtask : t_modes
   task automatic t_sync;
      int n;
      n = 0;
      @(negedge mclk);
      sync = 1'b1;
      while (dSync !== 1'b1 && n < 200)
      begin
         @(negedge mclk);
         n++;
      end
      chk(n, 72);
      sync = 1'b0;
   endtask : t_sync
   task automatic t_reload;
      @(negedge mclk);
      ceN = 1'b0;
      repeat (2) @(negedge mclk);
      ceN = 1'b1;
      t_load();
   endtask : t_reload
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   initial
   begin
      #200000;
      n_mismatch++;
      conclude();
   end
   initial
   begin
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      t_load();
      t_modes();
      t_sync();
      t_reload();
      t_modes();
      conclude();
   end
endmodule : tb_top
